// ==== core/brf_pkg.sv ====
// shared constants, types and threshold helpers for the block memory
package brf_pkg;

    // ------------------------------------------------------------
    // sizes and reset values
    // ------------------------------------------------------------
    localparam int BRF_DATA_W = 18;
    localparam int BRF_ADDR_W = 9;
    localparam int BRF_CS_W = 3;
    localparam int BRF_PTR_W = 14;
    localparam int BRF_RAM_DEPTH = 512;
    localparam int BRF_FIFO_DEPTH = 8;
    localparam int BRF_PORTS = 2;
    localparam logic [BRF_DATA_W-1:0] BRF_UNINIT_WORD = 18'h00000;
    localparam logic [BRF_DATA_W-1:0] BRF_DOUT_RESET = 18'h00000;
    localparam logic [1:0] BRF_REL_ASSERTED = 2'h3;
    localparam logic [1:0] BRF_REL_IDLE = 2'h0;
    localparam logic BRF_EMPTY_RESET = 1'h1;
    localparam logic BRF_ALMOST_EMPTY_RESET = 1'h1;
    localparam logic BRF_FULL_RESET = 1'h0;

    // ------------------------------------------------------------
    // modes
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        BRF_WB_NORMAL = 2'h0,
        BRF_WB_PASS_WRITE_DATA_OUT = 2'h1,
        BRF_WB_OLD_DATA_OUT_ON_WRITE = 2'h2
    } brf_write_output_behaviour_t;

    typedef enum logic [2:0] {
        BRF_W1 = 3'h0,
        BRF_W2 = 3'h1,
        BRF_W4 = 3'h2,
        BRF_W9 = 3'h3,
        BRF_W18 = 3'h4
    } brf_port_width_t;

    typedef struct packed {
        logic output_pipeline_option; // 1: output_registered
        logic reset_style; // 1: asynchronous
        logic reset_deassert_style; // 1: released on the clock
        logic global_set_reset_enable;
    } brf_cfg_t;

    typedef struct packed {
        logic [BRF_CS_W-1:0] chip_select_match_value;
        brf_write_output_behaviour_t write_output_behaviour;
        brf_port_width_t port_width;
    } brf_port_cfg_t;

    typedef struct packed {
        logic [BRF_CS_W-1:0] cs;
        logic en;
        logic we;
        logic [BRF_ADDR_W-1:0] addr;
        logic [BRF_DATA_W-1:0] din;
    } brf_port_req_t;

    // ------------------------------------------------------------
    // flag threshold helpers for user configuration
    // ------------------------------------------------------------
    function automatic int brf_port_weight(brf_port_width_t w);
        case (w)
            BRF_W2: return 2;
            BRF_W4: return 4;
            BRF_W9: return 8;
            BRF_W18: return 16;
            default: return 1;
        endcase
    endfunction : brf_port_weight

    function automatic logic [BRF_PTR_W-1:0] brf_fill_point(int lvl, brf_port_width_t w);
        return BRF_PTR_W'((lvl - 1) * brf_port_weight(w) + 1);
    endfunction : brf_fill_point

    function automatic logic [BRF_PTR_W-1:0] brf_drain_point(int lvl, brf_port_width_t w);
        return BRF_PTR_W'(lvl * brf_port_weight(w) + brf_port_weight(w) - 1);
    endfunction : brf_drain_point

    function automatic logic [BRF_PTR_W-1:0] brf_full_threshold(int n, brf_port_width_t w);
        return brf_fill_point(n, w);
    endfunction : brf_full_threshold

    function automatic logic [BRF_PTR_W-1:0] brf_full_minus_one_threshold(int n,
        brf_port_width_t w);
        return brf_fill_point(n - 1, w);
    endfunction : brf_full_minus_one_threshold

    function automatic logic [BRF_PTR_W-1:0] brf_almost_empty_plus_one_threshold(int n,
        brf_port_width_t w);
        return brf_drain_point(n + 1, w);
    endfunction : brf_almost_empty_plus_one_threshold

endpackage : brf_pkg

// ==== core/brf_block.sv ====
// block memory: dual port ram with output options plus a flagged fifo
`timescale 1ns/1ns

// ------------------------------------------------------------
// fifo buffer
// ------------------------------------------------------------
module brf_fifo #(
    parameter int WIDTH = brf_pkg::BRF_DATA_W,
    parameter int DEPTH = brf_pkg::BRF_FIFO_DEPTH,
    parameter int CW = $clog2(DEPTH) + 1
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready,
    input wire logic [CW-1:0] af_level,
    input wire logic [CW-1:0] ae_level,
    output logic full,
    output logic almost_full,
    output logic empty,
    output logic almost_empty
);
    localparam int PW = $clog2(DEPTH);

    generate
        if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || CW != PW + 1) begin : g_bad
            $error("brf_fifo: depth must be a power of two, at least 2");
        end
    endgenerate

    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [WIDTH-1:0] mem_next [DEPTH];
    logic [PW-1:0] wr_ptr_reg, wr_ptr_next, rd_ptr_reg, rd_ptr_next;
    logic [CW-1:0] count_reg, count_next;
    logic full_reg, full_next, af_reg, af_next;
    logic empty_reg, empty_next, ae_reg, ae_next;
    logic do_wr, do_rd;

    // ------------------------------------------------------------
    // pointers and flags
    // ------------------------------------------------------------
    always_comb begin
        do_wr = in_valid & ~full_reg;
        do_rd = out_ready & ~empty_reg;
        wr_ptr_next = do_wr ? PW'(wr_ptr_reg + 1'b1) : wr_ptr_reg;
        rd_ptr_next = do_rd ? PW'(rd_ptr_reg + 1'b1) : rd_ptr_reg;
        count_next = CW'(count_reg + CW'(do_wr) - CW'(do_rd));
        // levels are absolute occupancies, not distances from the ends
        full_next = count_next == CW'(DEPTH);
        af_next = count_next >= af_level;
        empty_next = count_next == '0;
        ae_next = count_next <= ae_level;
    end

    genvar gi;
    generate
        for (gi = 0; gi < DEPTH; gi++) begin : g_entry
            assign mem_next[gi] = (do_wr && wr_ptr_reg == PW'(gi)) ? in_data : mem_reg[gi];
        end
    endgenerate

    // flags are registered from the next count, so a caller sees them on the same edge as the move
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg <= '0;
            full_reg <= brf_pkg::BRF_FULL_RESET;
            af_reg <= brf_pkg::BRF_FULL_RESET;
            empty_reg <= brf_pkg::BRF_EMPTY_RESET;
            ae_reg <= brf_pkg::BRF_ALMOST_EMPTY_RESET;
        end else begin
            wr_ptr_reg <= wr_ptr_next;
            rd_ptr_reg <= rd_ptr_next;
            count_reg <= count_next;
            full_reg <= full_next;
            af_reg <= af_next;
            empty_reg <= empty_next;
            ae_reg <= ae_next;
        end
    end

    // data store is not cleared: only pointers decide what is valid
    always_ff @(posedge clk) begin
        mem_reg <= mem_next;
    end

    assign in_ready = ~full_reg;
    assign out_valid = ~empty_reg;
    assign out_data = mem_reg[rd_ptr_reg];
    assign full = full_reg;
    assign almost_full = af_reg;
    assign empty = empty_reg;
    assign almost_empty = ae_reg;

endmodule : brf_fifo

// What this block does
// - locations without a supplied value hold zero; supplied ones hold their value.
// - output option adds one register stage after the array, or none.
// - synchronous reset style acts on the edge; asynchronous acts at once.
// - the three chip select bits act as top address bits across eight blocks.
// - an access is served only when chip select equals the static match value.
// - each port has its own chip select match value.
// - normal write mode keeps the previous read data during a write.
// - write-through mode shows the data being written on the writing port.
// - read-before-write shows old contents; only at 9- and 18-bit widths.
// - each port selects its own write output behaviour.
// - a per-instance option links the memory to the global set/reset.
// - in asynchronous style, reset release is either clocked or immediate.
// - empty trips at zero; empty and almost-empty are high after reset.
// - the fifo runs on one clock: empty and full flags all register on clk.
module brf_block #(
    parameter int DEPTH = brf_pkg::BRF_RAM_DEPTH,
    parameter int FIFO_DEPTH = brf_pkg::BRF_FIFO_DEPTH,
    parameter logic [brf_pkg::BRF_DATA_W-1:0] INIT_VALUE [DEPTH] = '{default: '0}
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire brf_pkg::brf_cfg_t cfg,
    input wire brf_pkg::brf_port_cfg_t port_a_cfg,
    input wire brf_pkg::brf_port_cfg_t port_b_cfg,
    input wire logic mem_rst_b,
    input wire logic gsr_b,
    input wire brf_pkg::brf_port_req_t port_a_req,
    input wire brf_pkg::brf_port_req_t port_b_req,
    output logic [brf_pkg::BRF_DATA_W-1:0] port_a_dout,
    output logic [brf_pkg::BRF_DATA_W-1:0] port_b_dout,
    output logic collision,
    input wire logic [brf_pkg::BRF_DATA_W-1:0] fifo_in_data,
    input wire logic fifo_in_valid,
    output logic fifo_in_ready,
    input wire logic fifo_rd_en,
    input wire logic [$clog2(FIFO_DEPTH):0] almost_full_level,
    input wire logic [$clog2(FIFO_DEPTH):0] almost_empty_level,
    output logic [brf_pkg::BRF_DATA_W-1:0] fifo_out_data,
    output logic fifo_out_valid,
    output logic fifo_full,
    output logic fifo_almost_full,
    output logic fifo_empty,
    output logic fifo_almost_empty
);
    localparam int DW = brf_pkg::BRF_DATA_W;
    localparam int AW = $clog2(DEPTH);

    generate
        if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || AW > brf_pkg::BRF_ADDR_W) begin : g_bad
            $error("brf_block: depth must be a power of two up to the address range");
        end
    endgenerate

    // ------------------------------------------------------------
    // reset steering
    // ------------------------------------------------------------
    logic port_rst_req, gsr_req, async_req, async_clr, sync_clr;
    logic [1:0] rel_reg, rel_next;

    always_comb begin
        gsr_req = cfg.global_set_reset_enable & ~gsr_b;
        port_rst_req = ~mem_rst_b | gsr_req;
        async_req = cfg.reset_style & port_rst_req;
        sync_clr = ~rst_b | (~cfg.reset_style & port_rst_req);
        rel_next = {rel_reg[0], 1'b0};
        // clocked release holds the clear two edges past the request
        async_clr = cfg.reset_deassert_style ? (async_req | rel_reg[1]) : async_req;
    end

    always_ff @(posedge clk or posedge async_req) begin
        if (async_req) begin
            rel_reg <= brf_pkg::BRF_REL_ASSERTED;
        end else if (!rst_b) begin
            rel_reg <= brf_pkg::BRF_REL_IDLE;
        end else begin
            rel_reg <= rel_next;
        end
    end

    // ------------------------------------------------------------
    // array and port access
    // ------------------------------------------------------------
    logic [DW-1:0] mem_reg [DEPTH];
    logic [DW-1:0] mem_next [DEPTH];
    brf_pkg::brf_port_req_t req [brf_pkg::BRF_PORTS];
    brf_pkg::brf_port_cfg_t pcfg [brf_pkg::BRF_PORTS];
    logic hit [brf_pkg::BRF_PORTS];
    logic wr [brf_pkg::BRF_PORTS];
    logic [AW-1:0] idx [brf_pkg::BRF_PORTS];
    logic collision_reg, collision_next;

    assign req[0] = port_a_req;
    assign req[1] = port_b_req;
    assign pcfg[0] = port_a_cfg;
    assign pcfg[1] = port_b_cfg;

    genvar gp, ge;
    generate
        for (gp = 0; gp < brf_pkg::BRF_PORTS; gp++) begin : g_port
            logic [DW-1:0] stage_reg, stage_next, dout_reg, dout_next, rd_word;
            logic rbw_ok;

            always_comb begin
                // cs forms the top address bits of a cascade of up to eight blocks
                hit[gp] = req[gp].en &
                    (req[gp].cs == pcfg[gp].chip_select_match_value);
                wr[gp] = hit[gp] & req[gp].we;
                idx[gp] = req[gp].addr[AW-1:0];
                rd_word = mem_reg[idx[gp]];
                rbw_ok = pcfg[gp].port_width == brf_pkg::BRF_W9 ||
                    pcfg[gp].port_width == brf_pkg::BRF_W18;
                stage_next = stage_reg;
                if (hit[gp] && !req[gp].we) begin
                    stage_next = rd_word;
                end else if (wr[gp]) begin
                    case (pcfg[gp].write_output_behaviour)
                        brf_pkg::BRF_WB_PASS_WRITE_DATA_OUT: begin
                            stage_next = req[gp].din;
                        end
                        brf_pkg::BRF_WB_OLD_DATA_OUT_ON_WRITE: begin
                            // narrow widths cannot show old data: they hold instead
                            stage_next = rbw_ok ? rd_word : stage_reg;
                        end
                        default: begin
                            stage_next = stage_reg;
                        end
                    endcase
                end
                dout_next = cfg.output_pipeline_option ? stage_reg : stage_next;
            end

            always_ff @(posedge clk or posedge async_clr) begin
                if (async_clr) begin
                    stage_reg <= brf_pkg::BRF_DOUT_RESET;
                    dout_reg <= brf_pkg::BRF_DOUT_RESET;
                end else if (sync_clr) begin
                    stage_reg <= brf_pkg::BRF_DOUT_RESET;
                    dout_reg <= brf_pkg::BRF_DOUT_RESET;
                end else begin
                    stage_reg <= stage_next;
                    dout_reg <= dout_next;
                end
            end
        end

        // port b wins a same-address double write; contents are then undefined anyway
        for (ge = 0; ge < DEPTH; ge++) begin : g_word
            assign mem_next[ge] = (wr[1] && idx[1] == AW'(ge)) ? req[1].din :
                                  (wr[0] && idx[0] == AW'(ge)) ? req[0].din : mem_reg[ge];
        end
    endgenerate

    // power-up contents come back on the system reset
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_reg[i] <= (INIT_VALUE[i] === 'x) ? brf_pkg::BRF_UNINIT_WORD : INIT_VALUE[i];
            end
        end else begin
            mem_reg <= mem_next;
        end
    end

    // collision report lets user logic discard the affected read data
    always_comb begin
        collision_next = hit[0] & hit[1] & (idx[0] == idx[1]) & (wr[0] | wr[1]);
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            collision_reg <= 1'b0;
        end else begin
            collision_reg <= collision_next;
        end
    end

    // ------------------------------------------------------------
    // fifo path
    // ------------------------------------------------------------
    logic [DW-1:0] f_data, f_s1_reg, f_s1_next, f_out_reg, f_out_next;
    logic f_valid, f_take, f_v1_reg, f_v1_next, f_vout_reg, f_vout_next;
    logic fifo_rst_b;

    assign fifo_rst_b = rst_b & ~gsr_req;

    brf_fifo #(
        .WIDTH(DW),
        .DEPTH(FIFO_DEPTH),
        .CW($clog2(FIFO_DEPTH) + 1)
    ) u_fifo (
        .clk(clk),
        .rst_b(fifo_rst_b),
        .in_data(fifo_in_data),
        .in_valid(fifo_in_valid),
        .in_ready(fifo_in_ready),
        .out_data(f_data),
        .out_valid(f_valid),
        .out_ready(fifo_rd_en),
        .af_level(almost_full_level),
        .ae_level(almost_empty_level),
        .full(fifo_full),
        .almost_full(fifo_almost_full),
        .empty(fifo_empty),
        .almost_empty(fifo_almost_empty)
    );

    always_comb begin
        f_take = fifo_rd_en & f_valid;
        f_s1_next = f_take ? f_data : f_s1_reg;
        f_v1_next = f_take;
        f_out_next = cfg.output_pipeline_option ? f_s1_reg : f_s1_next;
        f_vout_next = cfg.output_pipeline_option ? f_v1_reg : f_v1_next;
    end

    always_ff @(posedge clk) begin
        if (!fifo_rst_b) begin
            f_s1_reg <= brf_pkg::BRF_DOUT_RESET;
            f_out_reg <= brf_pkg::BRF_DOUT_RESET;
            f_v1_reg <= 1'b0;
            f_vout_reg <= 1'b0;
        end else begin
            f_s1_reg <= f_s1_next;
            f_out_reg <= f_out_next;
            f_v1_reg <= f_v1_next;
            f_vout_reg <= f_vout_next;
        end
    end

    assign port_a_dout = g_port[0].dout_reg;
    assign port_b_dout = g_port[1].dout_reg;
    assign collision = collision_reg;
    assign fifo_out_data = f_out_reg;
    assign fifo_out_valid = f_vout_reg;

endmodule : brf_block

// ==== tb/brf_block_sva.sv ====
// concurrent checks on the block memory ports
`timescale 1ns/1ns
module brf_block_chk (
    input wire logic clk,
    input wire logic rst_b,
    input wire brf_pkg::brf_cfg_t cfg,
    input wire brf_pkg::brf_port_cfg_t port_a_cfg,
    input wire brf_pkg::brf_port_cfg_t port_b_cfg,
    input wire logic mem_rst_b,
    input wire logic gsr_b,
    input wire brf_pkg::brf_port_req_t port_a_req,
    input wire brf_pkg::brf_port_req_t port_b_req,
    input wire logic [brf_pkg::BRF_DATA_W-1:0] port_a_dout,
    input wire logic [brf_pkg::BRF_DATA_W-1:0] port_b_dout,
    input wire logic collision,
    input wire logic fifo_in_ready,
    input wire logic fifo_rd_en,
    input wire logic fifo_out_valid,
    input wire logic fifo_full,
    input wire logic fifo_empty,
    input wire logic fifo_almost_empty
);
    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);
    logic a_hit;
    logic b_hit;
    logic piped;
    // a reset of the ports in flight would spoil the hold checks, so it is left out
    assign a_hit = port_a_req.en && port_a_req.cs == port_a_cfg.chip_select_match_value
        && mem_rst_b && gsr_b;
    assign b_hit = port_b_req.en && port_b_req.cs == port_b_cfg.chip_select_match_value
        && mem_rst_b && gsr_b;
    assign piped = cfg.output_pipeline_option;
    a_reset_flags: assert property (disable iff (1'b0) !rst_b |=>
        fifo_empty && fifo_almost_empty && !fifo_full) else $error("fifo flags wrong after reset");
    a_full_refuses: assert property (fifo_full |-> !fifo_in_ready)
        else $error("ready while full");
    a_empty_no_read: assert property (fifo_rd_en && fifo_empty && !piped |=>
        !fifo_out_valid) else $error("word delivered from empty fifo");
    a_read_answer: assert property (fifo_rd_en && !fifo_empty |->
        ##1 (fifo_out_valid || piped) ##1 (fifo_out_valid || !piped))
        else $error("fifo read not answered in time");
    a_write_hold: assert property (a_hit && port_a_req.we && !piped
        && (port_a_cfg.write_output_behaviour == brf_pkg::BRF_WB_NORMAL
        || port_a_cfg.port_width inside {brf_pkg::BRF_W1, brf_pkg::BRF_W2, brf_pkg::BRF_W4})
        |=> $stable(port_a_dout)) else $error("port a output moved on write");
    a_pass_write: assert property (b_hit && port_b_req.we && !piped &&
        port_b_cfg.write_output_behaviour == brf_pkg::BRF_WB_PASS_WRITE_DATA_OUT
        |=> port_b_dout == $past(port_b_req.din)) else $error("write data not passed out");
    a_select_miss: assert property (port_a_req.en && mem_rst_b && gsr_b && !piped
        && port_a_req.cs != port_a_cfg.chip_select_match_value |=> $stable(port_a_dout))
        else $error("unselected access served");
    a_same_addr_flag: assert property (a_hit && b_hit
        && port_a_req.addr == port_b_req.addr && (port_a_req.we || port_b_req.we) |=> collision)
        else $error("collision not flagged");
    a_sync_mem_reset: assert property (!cfg.reset_style && !mem_rst_b |=>
        port_a_dout == '0) else $error("clocked output reset missed");
    a_async_mem_reset: assert property (cfg.reset_style && !mem_rst_b |->
        port_a_dout == '0) else $error("immediate output reset missed");
    c_collision: cover property (collision);
    c_full: cover property (fifo_full && !fifo_in_ready);
    c_empty_read: cover property (fifo_rd_en && fifo_empty);
endmodule : brf_block_chk

bind brf_block brf_block_chk u_chk (.clk(clk), .rst_b(rst_b), .cfg(cfg),
    .port_a_cfg(port_a_cfg), .port_b_cfg(port_b_cfg), .mem_rst_b(mem_rst_b), .gsr_b(gsr_b),
    .port_a_req(port_a_req), .port_b_req(port_b_req), .port_a_dout(port_a_dout),
    .port_b_dout(port_b_dout), .collision(collision), .fifo_in_ready(fifo_in_ready),
    .fifo_rd_en(fifo_rd_en), .fifo_out_valid(fifo_out_valid), .fifo_full(fifo_full),
    .fifo_empty(fifo_empty), .fifo_almost_empty(fifo_almost_empty));

// ==== tb/brf_reader_model.sv ====
// fifo reader standing in for user logic on the read side
`timescale 1ns/1ns
module brf_reader_model (
    input wire logic clk,
    input wire logic go,
    input wire logic stall,
    input wire logic force_rd,
    input wire logic fifo_empty,
    input wire logic fifo_out_valid,
    input wire logic [17:0] fifo_out_data,
    output logic fifo_rd_en,
    output int got_count
);
    // ------------------------------------------------------------
    // request and capture
    // ------------------------------------------------------------
    logic [17:0] got [16];
    initial begin
        fifo_rd_en = 1'b0;
        got_count = 0;
    end
    // falling edge: the registered empty flag has settled by then
    always @(negedge clk) begin
        fifo_rd_en <= force_rd || (go && !stall && !fifo_empty);
    end
    always @(posedge clk) begin
        if (fifo_out_valid && got_count < 16) begin
            got[got_count] <= fifo_out_data;
            got_count <= got_count + 1;
        end
    end
endmodule : brf_reader_model

// ==== tb/testbench.sv ====
// self-checking bench for the block memory and its fifo
`timescale 1ns/1ns
module testbench;
    // ------------------------------------------------------------
    // signals and instances
    // ------------------------------------------------------------
    localparam logic [17:0] INIT_TAB [16] = '{1: 18'h12345, default: 18'h00000};
    logic clk, rst_b, mem_rst_b, gsr_b, fifo_in_valid, fifo_in_ready, fifo_rd_en;
    logic collision, fifo_out_valid, fifo_full, fifo_af, fifo_empty, fifo_ae;
    logic rd_go, rd_stall, rd_force;
    logic [17:0] pa_dout, pb_dout, fifo_in_data, fifo_out_data;
    logic [3:0] af_lvl, ae_lvl;
    brf_pkg::brf_cfg_t cfg;
    brf_pkg::brf_port_cfg_t pa_cfg, pb_cfg;
    brf_pkg::brf_port_req_t pa_req, pb_req;
    int n_mismatch, n_compared, got_count;
    brf_block #(.DEPTH(16), .FIFO_DEPTH(8), .INIT_VALUE(INIT_TAB)) dut (.clk(clk),
        .rst_b(rst_b), .cfg(cfg), .port_a_cfg(pa_cfg), .port_b_cfg(pb_cfg),
        .mem_rst_b(mem_rst_b), .gsr_b(gsr_b), .port_a_req(pa_req), .port_b_req(pb_req),
        .port_a_dout(pa_dout), .port_b_dout(pb_dout), .collision(collision),
        .fifo_in_data(fifo_in_data), .fifo_in_valid(fifo_in_valid),
        .fifo_in_ready(fifo_in_ready), .fifo_rd_en(fifo_rd_en), .almost_full_level(af_lvl),
        .almost_empty_level(ae_lvl), .fifo_out_data(fifo_out_data),
        .fifo_out_valid(fifo_out_valid), .fifo_full(fifo_full), .fifo_almost_full(fifo_af),
        .fifo_empty(fifo_empty), .fifo_almost_empty(fifo_ae));
    brf_reader_model rdr (.clk(clk), .go(rd_go), .stall(rd_stall), .force_rd(rd_force),
        .fifo_empty(fifo_empty), .fifo_out_valid(fifo_out_valid),
        .fifo_out_data(fifo_out_data), .fifo_rd_en(fifo_rd_en), .got_count(got_count));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic check(input logic [17:0] seen, input logic [17:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic final_report;
        $display("compared %0d mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : final_report
    // one access, then a quiet cycle so the next call never re-drives in the same step
    task automatic acc(input logic b, input logic we, input logic [2:0] cs,
                       input logic [8:0] a, input logic [17:0] d);
        brf_pkg::brf_port_req_t r;
        r = '{cs: cs, en: 1'b1, we: we, addr: a, din: d};
        if (b) pb_req = r;
        else pa_req = r;
        @(negedge clk);
        pa_req.en = 1'b0;
        pb_req.en = 1'b0;
        @(negedge clk);
    endtask : acc
    task automatic push(input int n, input logic [17:0] base);
        for (int i = 0; i < n; i++) begin
            fifo_in_data = base + 18'(i);
            fifo_in_valid = 1'b1;
            @(negedge clk);
        end
        fifo_in_valid = 1'b0;
        @(negedge clk);
    endtask : push
    // ------------------------------------------------------------
    // sequence
    // ------------------------------------------------------------
    initial begin
        cfg = '0;
        pa_cfg = '{3'h5, brf_pkg::BRF_WB_NORMAL, brf_pkg::BRF_W18};
        pb_cfg = '{3'h2, brf_pkg::BRF_WB_PASS_WRITE_DATA_OUT, brf_pkg::BRF_W18};
        pa_req = '0;
        pb_req = '0;
        {rst_b, fifo_in_valid, rd_go, rd_stall, rd_force} = 5'h00;
        {mem_rst_b, gsr_b} = 2'h3;
        fifo_in_data = '0;
        af_lvl = 4'h6;
        ae_lvl = 4'h2;
        n_mismatch = 0;
        n_compared = 0;
        repeat (10) @(negedge clk);
        rst_b = 1'b1;
        check(fifo_empty, 1'b1);
        check(fifo_ae, 1'b1);
        check(brf_pkg::brf_fill_point(14, brf_pkg::BRF_W18), 18'h000D1);
        check(brf_pkg::brf_drain_point(8, brf_pkg::BRF_W9), 18'h00047);
        acc(0, 0, 3'h5, 9'h001, 18'h00000);
        check(pa_dout, 18'h12345);
        acc(0, 1, 3'h5, 9'h004, 18'h0ABCD);
        check(pa_dout, 18'h12345);
        acc(0, 1, 3'h4, 9'h005, 18'h3FFFF);
        acc(0, 0, 3'h5, 9'h005, 18'h00000);
        check(pa_dout, 18'h00000);
        acc(0, 0, 3'h4, 9'h004, 18'h00000);
        check(pa_dout, 18'h00000);
        acc(1, 1, 3'h2, 9'h007, 18'h2AAAA);
        check(pb_dout, 18'h2AAAA);
        acc(1, 0, 3'h2, 9'h004, 18'h00000);
        check(pb_dout, 18'h0ABCD);
        pa_req = '{3'h5, 1'b1, 1'b1, 9'h006, 18'h00001};
        pb_req = '{3'h2, 1'b1, 1'b1, 9'h006, 18'h00002};
        @(negedge clk);
        pa_req.en = 1'b0;
        pb_req.en = 1'b0;
        check(collision, 1'b1);
        @(negedge clk);
        pa_cfg.write_output_behaviour = brf_pkg::BRF_WB_OLD_DATA_OUT_ON_WRITE;
        acc(0, 1, 3'h5, 9'h004, 18'h11111);
        check(pa_dout, 18'h0ABCD);
        pa_cfg.port_width = brf_pkg::BRF_W4;
        acc(0, 1, 3'h5, 9'h004, 18'h22222);
        check(pa_dout, 18'h0ABCD);
        acc(0, 0, 3'h5, 9'h004, 18'h00000);
        check(pa_dout, 18'h22222);
        mem_rst_b = 1'b0;
        @(negedge clk);
        mem_rst_b = 1'b1;
        check(pa_dout, 18'h00000);
        acc(0, 0, 3'h5, 9'h004, 18'h00000);
        {cfg.reset_style, cfg.reset_deassert_style} = 2'h3;
        mem_rst_b = 1'b0;
        #1 check(pa_dout, 18'h00000);
        @(negedge clk);
        mem_rst_b = 1'b1;
        cfg.output_pipeline_option = 1'b1;
        acc(0, 0, 3'h5, 9'h004, 18'h00000);
        pa_req = '{3'h5, 1'b1, 1'b0, 9'h001, 18'h00000};
        @(negedge clk);
        pa_req.en = 1'b0;
        check(pa_dout, 18'h00000);
        @(negedge clk);
        check(pa_dout, 18'h12345);
        cfg.output_pipeline_option = 1'b0;
        push(2, 18'h00100);
        check(fifo_ae, 1'b1);
        gsr_b = 1'b0;
        @(negedge clk);
        gsr_b = 1'b1;
        check(fifo_empty, 1'b0);
        push(3, 18'h00102);
        check(fifo_ae, 1'b0);
        check(fifo_af, 1'b0);
        push(1, 18'h00105);
        check(fifo_af, 1'b1);
        push(3, 18'h00106);
        check(fifo_full, 1'b1);
        check(fifo_in_ready, 1'b0);
        {rd_stall, rd_go} = 2'h3;
        repeat (3) @(negedge clk);
        check(18'(got_count), 18'h00000);
        rd_stall = 1'b0;
        for (int i = 0; i < 200 && got_count < 8; i++) @(negedge clk);
        if (got_count < 8) begin
            n_mismatch++;
            final_report();
        end
        rd_force = 1'b1;
        repeat (3) @(negedge clk);
        rd_force = 1'b0;
        repeat (3) @(negedge clk);
        check(18'(got_count), 18'h00008);
        for (int i = 0; i < 8; i++) check(rdr.got[i], 18'h00100 + 18'(i));
        check(fifo_empty, 1'b1);
        rd_go = 1'b0;
        cfg.global_set_reset_enable = 1'b1;
        push(1, 18'h00200);
        gsr_b = 1'b0;
        @(negedge clk);
        gsr_b = 1'b1;
        check(fifo_empty, 1'b1);
        final_report();
    end
endmodule : testbench
